// ===== design/spi_status_word_reporter.sv
// spi slave that shifts the fixed and extended status word out
`include "status_consts.svh"

module spi_status_word_reporter (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // spi pins, asynchronous to MCLK
  input wire logic SCLK,
  input wire logic CS_B,
  input wire logic MOSI,
  output logic MISO_O,
  output logic MISO_OE,
  // flag sources from the device, on MCLK
  input wire status_pkg::src_set_s SRC_SET,
  input wire status_pkg::src_set_s SRC_ACTIVE,
  // observation
  output logic [15:0] STATUS_WORD,
  output logic [8:0] FLAG_CLEAR
);

  import status_pkg::*;

  logic sclk_s;
  logic cs_b_s;
  logic mosi_s;
  logic sclk_d_reg;
  logic cs_b_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  // each pin passes two flops before any logic reads it
  sync2 #(
    .WIDTH(1)
  ) u_sclk_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(SCLK),
    .q(sclk_s)
  );

  sync2 #(
    .WIDTH(1)
  ) u_cs_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(CS_B),
    .q(cs_b_s)
  );

  sync2 #(
    .WIDTH(1)
  ) u_mosi_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(MOSI),
    .q(mosi_s)
  );

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      sclk_d_reg <= 1'b0;
      // matches the synchroniser's zero reset, else the first edge after
      // reset would look like a select fall and open a false frame
      cs_b_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_b_d_reg <= cs_b_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign cs_fall = cs_b_d_reg & ~cs_b_s;
  assign cs_rise = ~cs_b_d_reg & cs_b_s;

  // latched source flags, one bank per kind of event
  logic [8:0] irq_pend;
  logic [8:0] wake_pend;
  logic [8:0] rst_pend;
  logic [8:0] clr_reg;
  logic [8:0] clr_next;

  // a read clears the named sources in all three banks at once
  src_latch #(
    .WIDTH(`SRC_N)
  ) u_irq_latch (
    .clk(MCLK),
    .rst_b(RST_B),
    .set(SRC_SET.irq),
    .active(SRC_ACTIVE.irq),
    .clr(clr_reg),
    .pending(irq_pend)
  );

  src_latch #(
    .WIDTH(`SRC_N)
  ) u_wake_latch (
    .clk(MCLK),
    .rst_b(RST_B),
    .set(SRC_SET.wake),
    .active(SRC_ACTIVE.wake),
    .clr(clr_reg),
    .pending(wake_pend)
  );

  src_latch #(
    .WIDTH(`SRC_N)
  ) u_rst_latch (
    .clk(MCLK),
    .rst_b(RST_B),
    .set(SRC_SET.rst),
    .active(SRC_ACTIVE.rst),
    .clr(clr_reg),
    .pending(rst_pend)
  );

  // status word, rebuilt every cycle from the pending flags
  logic [8:0] any_pend;
  logic [15:0] status_reg;
  logic [15:0] status_next;

  // detail bits do not care which bank set them
  assign any_pend = irq_pend | wake_pend | rst_pend;

  always_comb begin
    status_next = `STATUS_RESET;
    status_next[`BIT_IRQ] = |irq_pend;
    status_next[`BIT_WAKE] = |wake_pend;
    status_next[`BIT_RST] = |rst_pend;
    status_next[`BIT_CAN_G] = any_pend[`SRC_CAN_BUS] | any_pend[`SRC_CAN_LOCALSIDE_SRC];
    status_next[`BIT_LIN_G] = any_pend[`SRC_LIN_SECOND] | any_pend[`SRC_LIN_FIRST];
    status_next[`BIT_IO_G] = any_pend[`SRC_IO_HI] | any_pend[`SRC_IO_LO];
    status_next[`BIT_SAFE_G] = any_pend[`SRC_SAFE];
    status_next[`BIT_SUPPLY_G] = any_pend[`SRC_SUPPLY_HI] | any_pend[`SRC_SUPPLY_LO];
    status_next[`SRC_CAN_BUS] = any_pend[`SRC_CAN_BUS];
    status_next[`SRC_CAN_LOCALSIDE_SRC] = any_pend[`SRC_CAN_LOCALSIDE_SRC];
    status_next[`SRC_LIN_SECOND] = any_pend[`SRC_LIN_SECOND];
    status_next[`SRC_LIN_FIRST] = any_pend[`SRC_LIN_FIRST];
    status_next[`SRC_IO_HI] = any_pend[`SRC_IO_HI];
    status_next[`SRC_IO_LO] = any_pend[`SRC_IO_LO];
    status_next[`SRC_SUPPLY_HI] = any_pend[`SRC_SUPPLY_HI];
    status_next[`SRC_SUPPLY_LO] = any_pend[`SRC_SUPPLY_LO];
  end

  // registered so the word cannot glitch while it is snapshotted
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // frame engine: mode 0, data sampled on rising sclk, shifted on falling
  frame_state_e state_reg;
  frame_state_e state_next;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic [4:0] rx_cnt_reg;
  logic [4:0] rx_cnt_next;
  logic [4:0] tx_cnt_reg;
  logic [4:0] tx_cnt_next;
  logic [1:0] cmd_reg;
  logic [1:0] cmd_next;
  logic miso_reg;
  logic miso_next;
  logic oe_reg;
  logic oe_next;
  logic [4:0] tx_idx;
  logic [4:0] addr;
  logic sub_hi;
  logic is_write;

  // index of the bit that the coming falling edge puts out
  assign tx_idx = tx_cnt_reg + 5'h01;
  assign addr = rx_reg[`ADDR_MSB:`ADDR_LSB];
  assign sub_hi = rx_reg[`SUB_BIT];
  assign is_write = (cmd_reg == `CMD_WRITE);

  // decode of which source flags a completed read frame has read
  function automatic logic [8:0] read_mask(input logic [4:0] a, input logic hi);
    logic [8:0] m;
    m = 9'h000;
    case (a)
      `ADDR_CAN: begin
        m[`SRC_CAN_BUS] = 1'b1;
        m[`SRC_CAN_LOCALSIDE_SRC] = 1'b1;
      end
      `ADDR_LIN_FIRST: m[`SRC_LIN_FIRST] = 1'b1;
      `ADDR_LIN_SECOND: m[`SRC_LIN_SECOND] = 1'b1;
      `ADDR_IO: m[hi ? `SRC_IO_HI : `SRC_IO_LO] = 1'b1;
      `ADDR_SUPPLY: m[hi ? `SRC_SUPPLY_HI : `SRC_SUPPLY_LO] = 1'b1;
      `ADDR_SAFE: m[`SRC_SAFE] = 1'b1;
      default: m = 9'h000;
    endcase
    return m;
  endfunction

  always_comb begin
    state_next = state_reg;
    word_next = word_reg;
    rx_next = rx_reg;
    rx_cnt_next = rx_cnt_reg;
    tx_cnt_next = tx_cnt_reg;
    cmd_next = cmd_reg;
    miso_next = miso_reg;
    oe_next = oe_reg;
    clr_next = 9'h000;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          // snapshot so the word holds steady through the frame
          word_next = status_reg;
          miso_next = status_reg[15];
          oe_next = 1'b1;
          rx_next = 16'h0000;
          rx_cnt_next = 5'h00;
          tx_cnt_next = 5'h00;
          cmd_next = 2'h0;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          oe_next = 1'b0;
          miso_next = 1'b0;
          state_next = ST_DONE;
        end else begin
          if (sclk_rise) begin
            rx_next = {rx_reg[14:0], mosi_s};
            // counts saturate so an overlong frame never wraps to a legal length
            if (rx_cnt_reg != 5'h1F) begin
              rx_cnt_next = rx_cnt_reg + 5'h01;
            end
            // command known after two rises, long before the extended byte starts
            if (rx_cnt_reg == (`CMD_BITS - 5'h01)) begin
              cmd_next = {rx_reg[0], mosi_s};
            end
          end
          if (sclk_fall) begin
            if (tx_cnt_reg != 5'h1F) begin
              tx_cnt_next = tx_idx;
            end
            // extended byte only for write frames, read frames pad with zero
            if (tx_idx < `FIXED_BITS) begin
              miso_next = word_reg[4'hF - tx_idx[3:0]];
            end else if (tx_idx < `FRAME_BITS && is_write) begin
              miso_next = word_reg[4'hF - tx_idx[3:0]];
            end else begin
              miso_next = 1'b0;
            end
          end
        end
      end
      ST_DONE: begin
        // short or long frames are discarded and clear nothing
        if (rx_cnt_reg == `FRAME_BITS && !is_write) begin
          clr_next = read_mask(addr, sub_hi);
        end
        state_next = ST_IDLE;
      end
      default: begin
        oe_next = 1'b0;
        miso_next = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      state_reg <= ST_IDLE;
      word_reg <= `STATUS_RESET;
      rx_reg <= 16'h0000;
      rx_cnt_reg <= 5'h00;
      tx_cnt_reg <= 5'h00;
      cmd_reg <= 2'h0;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
      clr_reg <= 9'h000;
    end else begin
      state_reg <= state_next;
      word_reg <= word_next;
      rx_reg <= rx_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_cnt_reg <= tx_cnt_next;
      cmd_reg <= cmd_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      clr_reg <= clr_next;
    end
  end

  // miso held low while disabled, so a stale bit never reaches the line
  assign MISO_O = miso_reg;
  assign MISO_OE = oe_reg;
  assign STATUS_WORD = status_reg;
  assign FLAG_CLEAR = clr_reg;

endmodule

// ===== design/src_latch.sv
// sticky source flags, cleared by a flag read once the failure is gone
module src_latch #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] active,
  input wire logic [WIDTH-1:0] clr,
  // state
  output logic [WIDTH-1:0] pending
);

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // set wins over a clear in the same cycle
  always_comb begin
    flag_next = set | (flag_reg & ~(clr & ~active));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign pending = flag_reg;

endmodule

// ===== design/status_consts.svh
// constants for the spi status word reporter
// Function
// - Every SPI frame shifts the status word out on the data output.
// - Command bits 01 (write) return the fixed byte then the extended byte.
// - Command bits 00 or 11 (read) return only the fixed status byte.
// - Bit 15 set while latched interrupt source flags wait to be read.
// - Bit 14 set while latched wake-up source flags wait to be read.
// - Bit 13 set while latched reset source flags wait to be read.
// - Bit 12 flags a CAN source, local side or bus side.
// - Bit 11 flags a source on the first or second LIN interface.
// - Bit 10 flags a source on the I/O interfaces.
// - Bit 9 flags a safe-state source.
// - Bit 8 flags a regulator or voltage monitoring source.
// - Bit 7 flags CAN bus side, bit 6 CAN local side.
// - Bit 5 flags the second LIN interface, bit 4 the first.
// - Bit 3 flags I/O high sub-address, bit 2 I/O low sub-address.
// - Bit 1 flags regulator high sub-address, bit 0 regulator low sub-address.
// - Latched flags clear only after an SPI read and once the failure recovered.
`ifndef STATUS_CONSTS_SVH
`define STATUS_CONSTS_SVH

// frame and command field
`define FRAME_BITS 5'h10
`define CMD_BITS 5'h02
`define FIXED_BITS 5'h08
`define CMD_WRITE 2'h1
`define ADDR_MSB 13
`define ADDR_LSB 9
`define SUB_BIT 7

// flag register addresses decoded from a read frame
`define ADDR_SUPPLY 5'h0F
`define ADDR_CAN 5'h10
`define ADDR_IO 5'h11
`define ADDR_SAFE 5'h12
`define ADDR_LIN_FIRST 5'h13
`define ADDR_LIN_SECOND 5'h14

// source index, also the detail bit position for 0..7
`define SRC_N 9
`define SRC_SUPPLY_LO 0
`define SRC_SUPPLY_HI 1
`define SRC_IO_LO 2
`define SRC_IO_HI 3
`define SRC_LIN_FIRST 4
`define SRC_LIN_SECOND 5
`define SRC_CAN_LOCALSIDE_SRC 6
`define SRC_CAN_BUS 7
`define SRC_SAFE 8

// status word bit positions
`define BIT_IRQ 15
`define BIT_WAKE 14
`define BIT_RST 13
`define BIT_CAN_G 12
`define BIT_LIN_G 11
`define BIT_IO_G 10
`define BIT_SAFE_G 9
`define BIT_SUPPLY_G 8

`define STATUS_RESET 16'h0000

`endif

// ===== design/status_pkg.sv
// types shared by the spi status word reporter
package status_pkg;

  // per source event pulses or levels, one bit per source index
  typedef struct packed {
    logic [8:0] irq;
    logic [8:0] wake;
    logic [8:0] rst;
  } src_set_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_DONE = 2'h3
  } frame_state_e;

endpackage

// ===== design/sync2.sv
// two flip-flop synchroniser for asynchronous pins
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// ===== tb/spi_master_model.sv
// spi master model, mode 0, msb first
module spi_master_model (
  // clock
  input wire logic mclk,
  // spi pins
  output logic sclk,
  output logic cs_b,
  output logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end
  // six mclk per phase, above the three the pin sync needs
  task automatic half();
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    half();
    cs_b = 1'b0;
    for (int k = 0; k < n; k++) begin
      mosi = tx[15 - k];
      half();
      rx = {rx[14:0], miso_oe ? miso_o : 1'bx};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_b = 1'b1;
    // released line flips so a stale bit cannot pass
    mosi = ~mosi;
  endtask
endmodule

// ===== tb/spi_status_word_reporter_tb.sv
// self-checking bench for the spi status word reporter
module spi_status_word_reporter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import status_pkg::*;
  logic mclk, rst_b, sclk, cs_b, mosi, miso_o, miso_oe;
  src_set_s src_set, src_active;
  logic [15:0] status_word;
  logic [8:0] flag_clear, p_irq, p_wake, p_rst;
  logic [31:0] lfsr;
  int num_errors, samples_checked;

  spi_status_word_reporter spi_status_word_reporter_i (.MCLK(mclk), .RST_B(rst_b),
    .SCLK(sclk), .CS_B(cs_b), .MOSI(mosi), .MISO_O(miso_o), .MISO_OE(miso_oe),
    .SRC_SET(src_set), .SRC_ACTIVE(src_active), .STATUS_WORD(status_word),
    .FLAG_CLEAR(flag_clear));
  spi_master_model spi_master_model_i (.mclk(mclk), .sclk(sclk), .cs_b(cs_b),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_word(input logic [8:0] i, w, r);
    logic [8:0] a;
    a = i | w | r;
    return {|i, |w, |r, |a[7:6], |a[5:4], |a[3:2], a[8], |a[1:0], a[7:0]};
  endfunction
  // sources cleared by a read of one flag register
  function automatic logic [8:0] clr_mask(input logic [4:0] adr, input logic sub);
    case (adr)
      5'h0F: return sub ? 9'h002 : 9'h001;
      5'h10: return 9'h0C0;
      5'h11: return sub ? 9'h008 : 9'h004;
      5'h12: return 9'h100;
      5'h13: return 9'h010;
      5'h14: return 9'h020;
      default: return 9'h000;
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // outputs at the first two edges after a release of reset
  task automatic after_reset();
    repeat (2) begin
      @(posedge mclk);
      #1;
      check("oe after reset", miso_oe, 16'h0000);
      check("word after reset", status_word, 16'h0000);
      check("clear after reset", flag_clear, 16'h0000);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    logic [15:0] tx, rx, w, e;
    logic [8:0] m;
    logic [1:0] cmd;
    int n;
    rst_b = 1'b0;
    src_set = '0;
    src_active = '0;
    {p_irq, p_wake, p_rst} = '0;
    lfsr = 32'hFFFD299E;
    num_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    #1;
    check("reset word", status_word, 16'h0000);
    rst_b = 1'b1;
    after_reset();
    $display("reset test done");
    for (int i = 0; i < 48; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge mclk);
      #1;
      src_set = lfsr[26:0] & {lfsr[4:0], lfsr[31:10]};
      // odd rounds keep the failure present so the read must not clear
      src_active = i[0] ? src_set : '0;
      {p_irq, p_wake, p_rst} = {p_irq, p_wake, p_rst} | src_set;
      @(posedge mclk);
      #1;
      src_set = '0;
      repeat (2) @(posedge mclk);
      #1;
      w = exp_word(p_irq, p_wake, p_rst);
      check("word after set", status_word, w);
      lfsr = lfsr_next(lfsr);
      cmd = (i < 4) ? i[1:0] : lfsr[29:28];
      tx = {cmd, 5'h0F + {2'h0, lfsr[2:0]}, lfsr[8], lfsr[7], lfsr[15:9]};
      n = (i % 8 == 7) ? 15 : 16;
      spi_master_model_i.frame(tx, n, rx);
      e = (cmd == 2'h1) ? w : {w[15:8], 8'h00};
      m = 9'h000;
      if (n == 16) begin
        check("miso word", rx, e);
        if (cmd != 2'h1) begin
          m = clr_mask(tx[13:9], tx[7]);
          p_irq &= ~(m & ~src_active.irq);
          p_wake &= ~(m & ~src_active.wake);
          p_rst &= ~(m & ~src_active.rst);
        end
      end else begin
        // one bit short: the word minus its last bit, and nothing cleared
        check("short miso word", rx, {1'b0, e[15:1]});
      end
      // the clear pulse stands for one cycle, four edges after select rises
      repeat (4) @(posedge mclk);
      #1;
      check("flag clear", {7'h00, flag_clear}, {7'h00, m});
      repeat (4) @(posedge mclk);
      #1;
      check("word after read", status_word, exp_word(p_irq, p_wake, p_rst));
      src_active = '0;
    end
    $display("random frame test done");
    // a reset in mid-run drops every pending flag and must not open a frame
    rst_b = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    after_reset();
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule

// ===== tb/status_word_properties.sv
// assertions watching the status word reporter ports
module status_word_properties (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // spi
  input wire logic CS_B,
  input wire logic MISO_OE,
  // flags and status
  input wire status_pkg::src_set_s SRC_SET,
  input wire logic [15:0] STATUS_WORD,
  input wire logic [8:0] FLAG_CLEAR
);
  timeunit 1ns;
  timeprecision 100ps;
  import status_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  logic [8:0] any_set;
  assign any_set = SRC_SET.irq | SRC_SET.wake | SRC_SET.rst;
  irq_summary_a: assert property ((|SRC_SET.irq) |-> ##2 STATUS_WORD[15])
    else $error("irq bit missing");
  wake_summary_a: assert property ((|SRC_SET.wake) |-> ##2 STATUS_WORD[14])
    else $error("wake bit missing");
  reset_summary_a: assert property ((|SRC_SET.rst) |-> ##2 STATUS_WORD[13])
    else $error("reset bit missing");
  can_group_a: assert property (STATUS_WORD[12] == (|STATUS_WORD[7:6]))
    else $error("can group bit wrong");
  lin_group_a: assert property (STATUS_WORD[11] == (|STATUS_WORD[5:4]))
    else $error("lin group bit wrong");
  io_group_a: assert property (STATUS_WORD[10] == (|STATUS_WORD[3:2]))
    else $error("io group bit wrong");
  safe_group_a: assert property (any_set[8] |-> ##2 STATUS_WORD[9])
    else $error("safe group bit missing");
  supply_group_a: assert property (STATUS_WORD[8] == (|STATUS_WORD[1:0]))
    else $error("supply group bit wrong");
  can_detail_a: assert property (any_set[7:6] != 2'h0 |->
    ##2 (STATUS_WORD[7:6] & $past(any_set[7:6], 2)) == $past(any_set[7:6], 2))
    else $error("can detail bits missing");
  miso_idle_a: assert property (CS_B [*6] |-> !MISO_OE)
    else $error("miso driven outside frame");
  clear_after_frame_a: assert property (FLAG_CLEAR != 9'h000 |-> $past(CS_B, 3))
    else $error("flag clear inside frame");
  oe_start_a: assert property ($rose(MISO_OE) |-> !$past(CS_B, 3))
    else $error("miso enabled without a frame");
  cover property (FLAG_CLEAR != 9'h000);
  cover property ($fell(MISO_OE));
  cover property (STATUS_WORD[15:13] == 3'h7);
endmodule

bind spi_status_word_reporter status_word_properties status_word_properties_i (
  .MCLK(MCLK), .RST_B(RST_B), .CS_B(CS_B), .MISO_OE(MISO_OE),
  .SRC_SET(SRC_SET), .STATUS_WORD(STATUS_WORD), .FLAG_CLEAR(FLAG_CLEAR));
